// ===== design/shc_standby_halt_control.sv
// standby, halt and oscillation settling control
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps

// What this block does
// - power_save_control changes only through the protected write sequence; hardware clears standby request on return to normal.
// - power_save_control resets to 00H; byte reads and writes.
// - watchdog-2 request wakes IDLE/STOP unless its wake mask is 1.
// - NMI pin request wakes IDLE/STOP unless its wake mask is 1.
// - maskable requests wake IDLE/STOP unless their wake mask is 1.
// - standby request bit 1 enters IDLE or STOP; 0 is normal; not HALT.
// - masks written together with standby request bit 1 are discarded if any mask bit is 1; all-zero masks are taken.
// - select 0 means IDLE, 1 means STOP; used only with standby request.
// - subclock disable 0 runs, 1 stops the subclock oscillator.
// - settle wait code 000 is 2^13 cycles, 001 2^15, doubling to 2^21.
// - settle select reset value 0 or 1 from the option setting.
// - settle select is byte wide; bits three to seven are zero.
// - settle count starts once the main oscillator runs again.
// - settle wait applies also with an external clock input.
// - HALT stops only the CPU clock; oscillators and peripherals run.
// - HALT with a pending unmasked request is entered then left at once.
// - HALT ends on any interrupt request or reset, back to normal.
// - in a handler, lower priority only ends HALT; higher is acknowledged.
module shc_standby_halt_control
	import shc_pkg::*;
#(
	parameter int SETTLE_LOG_0 = SETTLE_LOG_C0,
	parameter int SETTLE_LOG_1 = SETTLE_LOG_C1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clkEn,
	input wire shc_bus_req_type busReq,
	output logic [7:0] busRdata,
	input wire logic haltExec,
	input wire shc_wake_type wakeReq,
	input wire logic mainOscRunning,
	input wire logic settleStrap,
	output shc_clk_ctrl_type clkCtrl,
	output logic wakeAck,
	output shc_state_type modeState
);

	// ********************************
	// state
	// ********************************
	typedef struct packed {
		shc_state_type st;
		logic [7:0] power_save_control;
		logic [7:0] power_save_mode;
		logic [OSCILLATION_SETTLE_SELECT_W-1:0] oscillation_settle_select;
		logic strapDone;
		logic armed;
		logic [7:0] rdata;
		logic wakeAck;
		logic [CNT_W-1:0] cnt;
		logic [2:0] nmiSync;
		logic nmiLvl;
		logic [2:0] oscSync;
		logic oscLvl;
	} shc_regs_type;

	shc_regs_type regs_r;
	shc_regs_type regs_nxt;

	logic pscWrite;
	logic haltWake;
	logic stbyWake;
	logic [4:0] settleLog;
	logic [7:0] pscNew;

	// ********************************
	// wake decode
	// ********************************
	always_comb begin
		haltWake = regs_r.nmiLvl | wakeReq.watchdog1NmiRequest
			| wakeReq.watchdog2NmiRequest | wakeReq.maskIrqReq;
		stbyWake = 1'b0;
		if (!regs_r.power_save_control[PSC_WDT2M] && wakeReq.watchdog2NmiRequest) begin
			stbyWake = 1'b1;
		end
		if (!regs_r.power_save_control[PSC_NMIM] && regs_r.nmiLvl) begin
			stbyWake = 1'b1;
		end
		if (!regs_r.power_save_control[PSC_MASKABLE_WAKE_MASK] && wakeReq.maskIrqReq) begin
			stbyWake = 1'b1;
		end
		if (regs_r.oscillation_settle_select == 3'h0) begin
			settleLog = 5'(SETTLE_LOG_0);
		end else begin
			settleLog = 5'(SETTLE_LOG_1) + 5'(regs_r.oscillation_settle_select) - 5'h01;
		end
	end

	// ********************************
	// next state
	// ********************************
	always_comb begin
		regs_nxt = regs_r;
		regs_nxt.rdata = 8'h00;
		regs_nxt.wakeAck = 1'b0;
		// nmi pin: level taken only when stages two and three agree
		regs_nxt.nmiSync = {regs_r.nmiSync[1:0], wakeReq.nmiPinReq};
		if (regs_r.nmiSync[1] == regs_r.nmiSync[2]) begin
			regs_nxt.nmiLvl = regs_r.nmiSync[2];
		end
		regs_nxt.oscSync = {regs_r.oscSync[1:0], mainOscRunning};
		if (regs_r.oscSync[1] == regs_r.oscSync[2]) begin
			regs_nxt.oscLvl = regs_r.oscSync[2];
		end

		if (!regs_r.strapDone) begin
			regs_nxt.oscillation_settle_select = {2'h0, settleStrap};
			regs_nxt.strapDone = 1'b1;
		end

		// one-shot unlock, spent by any write
		pscWrite = 1'b0;
		if (busReq.wr) begin
			regs_nxt.armed = 1'b0;
			if (busReq.addr == ADDR_PROT) begin
				regs_nxt.armed = (busReq.wdata == PROT_KEY);
			end else if (busReq.addr == ADDR_PSC) begin
				pscWrite = regs_r.armed;
			end else if (busReq.addr == ADDR_POWER_SAVE_MODE) begin
				regs_nxt.power_save_mode = busReq.wdata;
			end else if (busReq.addr == ADDR_OSCILLATION_SETTLE_SELECT) begin
				regs_nxt.oscillation_settle_select = busReq.wdata[OSCILLATION_SETTLE_SELECT_W-1:0];
				regs_nxt.strapDone = 1'b1;
			end
		end

		// masks discarded when any mask bit is written 1 with standby request
		pscNew = busReq.wdata;
		if (busReq.wdata[PSC_STBY] && |(busReq.wdata & PSC_MASKS)) begin
			pscNew = (busReq.wdata & ~PSC_MASKS) | (regs_r.power_save_control & PSC_MASKS);
		end
		if (pscWrite) begin
			regs_nxt.power_save_control = pscNew;
		end

		// byte reads, data one cycle later
		if (busReq.rd) begin
			if (busReq.addr == ADDR_PSC) begin
				regs_nxt.rdata = regs_r.power_save_control;
			end else if (busReq.addr == ADDR_POWER_SAVE_MODE) begin
				regs_nxt.rdata = regs_r.power_save_mode;
			end else if (busReq.addr == ADDR_OSCILLATION_SETTLE_SELECT) begin
				regs_nxt.rdata = {5'h00, regs_r.oscillation_settle_select};
			end else if (busReq.addr == ADDR_STAT) begin
				regs_nxt.rdata = {2'h0, regs_r.st};
			end else begin
				regs_nxt.rdata = 8'h00;
			end
		end

		case (regs_r.st)
			ST_NORMAL: begin
				// standby request starts IDLE or STOP
				if (pscWrite && pscNew[PSC_STBY]) begin
					if (regs_r.power_save_mode[POWER_SAVE_MODE_SEL]) begin
						regs_nxt.st = ST_STOP;
					end else begin
						regs_nxt.st = ST_IDLE;
					end
				end else if (haltExec) begin
					regs_nxt.st = ST_HALT;
				end
			end
			ST_HALT: begin
				if (haltWake) begin
					regs_nxt.st = ST_NORMAL;
					regs_nxt.wakeAck = wakeReq.irqHigherPrio
						| regs_r.nmiLvl
						| wakeReq.watchdog1NmiRequest
						| wakeReq.watchdog2NmiRequest;
				end
			end
			ST_IDLE: begin
				if (stbyWake) begin
					regs_nxt.st = ST_NORMAL;
					regs_nxt.power_save_control[PSC_STBY] = 1'b0;
				end
			end
			ST_STOP: begin
				// forget the pre-stop oscillator level
				// a stale high here would skip the start-up gap
				regs_nxt.oscSync = 3'h0;
				regs_nxt.oscLvl = 1'b0;
				if (stbyWake) begin
					regs_nxt.st = ST_OSCWAIT;
				end
			end
			ST_OSCWAIT: begin
				if (regs_r.oscLvl) begin
					regs_nxt.st = ST_SETTLE;
					regs_nxt.cnt = CNT_W'((23'h000001 << settleLog)
						- 23'h000002);
				end
			end
			ST_SETTLE: begin
				// wait also applies to external clock
				if (regs_r.cnt == '0) begin
					regs_nxt.st = ST_NORMAL;
					regs_nxt.power_save_control[PSC_STBY] = 1'b0;
				end else begin
					regs_nxt.cnt = regs_r.cnt - CNT_W'(1);
				end
			end
			default: begin
				regs_nxt.st = ST_NORMAL;
			end
		endcase
	end

	// ********************************
	// registers
	// ********************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			regs_r.st <= ST_NORMAL;
			regs_r.power_save_control <= PSC_RST;
			regs_r.power_save_mode <= POWER_SAVE_MODE_RST;
			regs_r.oscillation_settle_select <= OSCILLATION_SETTLE_SELECT_RST;
			regs_r.strapDone <= 1'b0;
			regs_r.armed <= 1'b0;
			regs_r.rdata <= 8'h00;
			regs_r.wakeAck <= 1'b0;
			regs_r.cnt <= '0;
			regs_r.nmiSync <= 3'h0;
			regs_r.nmiLvl <= 1'b0;
			regs_r.oscSync <= 3'h0;
			regs_r.oscLvl <= 1'b0;
		end else if (clkEn) begin
			regs_r <= regs_nxt;
		end
	end

	// ********************************
	// outputs
	// ********************************
	always_comb begin
		busRdata = regs_r.rdata;
		wakeAck = regs_r.wakeAck;
		modeState = regs_r.st;
		// HALT gates the CPU clock only
		clkCtrl.cpuClkStop = (regs_r.st != ST_NORMAL);
		clkCtrl.periphClkStop = !(regs_r.st inside {ST_NORMAL, ST_HALT});
		clkCtrl.mainOscStop = (regs_r.st == ST_STOP)
			| (regs_r.st == ST_OSCWAIT);
		clkCtrl.subOscStop = regs_r.power_save_mode[POWER_SAVE_MODE_SUBSTOP];
	end

	// ********************************
	// assertions
	// ********************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	AST_PSC_UNLOCKED: assert property (
		clkEn && busReq.wr && busReq.addr == ADDR_PSC && !regs_r.armed
		|=> $stable(regs_r.power_save_control))
		else $error("psc changed without unlock");
	AST_MASK_DISCARD: assert property (
		clkEn && pscWrite && busReq.wdata[PSC_STBY]
		|=> (regs_r.power_save_control & PSC_MASKS) == ($past(regs_r.power_save_control) & PSC_MASKS))
		else $error("masks taken with standby request");
	AST_WDT2_WAKE: assert property (
		clkEn && regs_r.st == ST_IDLE && !regs_r.power_save_control[PSC_WDT2M]
		&& wakeReq.watchdog2NmiRequest |=> modeState == ST_NORMAL)
		else $error("watchdog-2 did not wake idle");
	AST_IDLE_HOLD: assert property (
		clkEn && regs_r.st == ST_IDLE && !stbyWake
		|=> modeState == ST_IDLE)
		else $error("idle left without unmasked wake");
	AST_INT_WAKE_STOP: assert property (
		clkEn && regs_r.st == ST_STOP && !regs_r.power_save_control[PSC_MASKABLE_WAKE_MASK]
		&& wakeReq.maskIrqReq |=> modeState == ST_OSCWAIT)
		else $error("maskable request did not wake stop");
	AST_STOP_ENTRY: assert property (
		clkEn && regs_r.st == ST_NORMAL && pscWrite
		&& busReq.wdata[PSC_STBY] && regs_r.power_save_mode[POWER_SAVE_MODE_SEL]
		|=> modeState == ST_STOP && clkCtrl.mainOscStop)
		else $error("stop not entered");
	AST_OSC_GATE: assert property (
		clkEn && regs_r.st == ST_OSCWAIT && !regs_r.oscLvl
		|=> modeState == ST_OSCWAIT)
		else $error("settle started before oscillator");
	AST_SETTLE_END: assert property (
		clkEn && regs_r.st == ST_SETTLE && regs_r.cnt == '0
		|=> modeState == ST_NORMAL && !regs_r.power_save_control[PSC_STBY])
		else $error("settle end wrong");
	AST_HALT_CLOCKS: assert property (
		modeState == ST_HALT
		|-> clkCtrl.cpuClkStop && !clkCtrl.periphClkStop
		&& !clkCtrl.mainOscStop)
		else $error("halt clock gating wrong");
	AST_HALT_EXIT: assert property (
		clkEn && regs_r.st == ST_HALT && haltWake
		|=> modeState == ST_NORMAL)
		else $error("halt not released");
	AST_LOW_PRIO: assert property (
		clkEn && regs_r.st == ST_HALT && haltWake && !regs_r.nmiLvl
		&& !wakeReq.watchdog1NmiRequest && !wakeReq.watchdog2NmiRequest
		&& !wakeReq.irqHigherPrio |=> !wakeAck)
		else $error("low priority request acknowledged");

	COV_HALT: cover property (modeState == ST_HALT ##1
		modeState == ST_NORMAL);
	COV_IDLE: cover property (modeState == ST_IDLE ##1
		modeState == ST_NORMAL);
	COV_STOP: cover property (modeState == ST_SETTLE ##1
		modeState == ST_NORMAL);
	COV_DISCARD: cover property (clkEn && pscWrite
		&& busReq.wdata[PSC_STBY] && |(busReq.wdata & PSC_MASKS));

endmodule

// ===== design/shc_pkg.sv
// constants and types shared by the standby and halt control block
package shc_pkg;

	// ********************************
	// register map
	// ********************************
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_PSC = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_POWER_SAVE_MODE = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_OSCILLATION_SETTLE_SELECT = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_PROT = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
	// arbitrary unlock value for the protected write
	localparam logic [7:0] PROT_KEY = 8'hA5;

	// ********************************
	// field positions and reset values
	// ********************************
	localparam int PSC_WDT2M = 6;
	localparam int PSC_NMIM = 5;
	localparam int PSC_MASKABLE_WAKE_MASK = 4;
	localparam int PSC_STBY = 1;
	localparam logic [7:0] PSC_MASKS = 8'h70;
	localparam int POWER_SAVE_MODE_SUBSTOP = 7;
	localparam int POWER_SAVE_MODE_SEL = 0;
	localparam logic [7:0] PSC_RST = 8'h00;
	localparam logic [7:0] POWER_SAVE_MODE_RST = 8'h00;
	localparam logic [2:0] OSCILLATION_SETTLE_SELECT_RST = 3'h1;
	localparam int OSCILLATION_SETTLE_SELECT_W = 3;

	// ********************************
	// settling counts
	// ********************************
	localparam int SETTLE_LOG_C0 = 13;
	localparam int SETTLE_LOG_C1 = 15;
	localparam int CNT_W = 22;

	typedef enum logic [5:0] {
		ST_NORMAL = 6'h01,
		ST_HALT = 6'h02,
		ST_IDLE = 6'h04,
		ST_STOP = 6'h08,
		ST_OSCWAIT = 6'h10,
		ST_SETTLE = 6'h20
	} shc_state_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} shc_bus_req_type;

	typedef struct packed {
		logic cpuClkStop;
		logic periphClkStop;
		logic mainOscStop;
		logic subOscStop;
	} shc_clk_ctrl_type;

	typedef struct packed {
		logic nmiPinReq;
		logic watchdog1NmiRequest;
		logic watchdog2NmiRequest;
		logic maskIrqReq;
		logic irqHigherPrio;
	} shc_wake_type;

endpackage

// ===== testbench/shc_osc_model.sv
// main oscillator start-up model facing the standby control block
`timescale 1ns/10ps
module shc_osc_model
	import shc_pkg::*;
#(
	parameter int START_DLY = 6
) (
	input wire logic clk_sys,
	input wire shc_state_type modeState,
	output logic mainOscRunning
);
	int cnt;
	initial begin
		mainOscRunning = 1'b1;
		cnt = 0;
	end
	// late edges after stop
	// external clock input gets no shortcut: same start-up gap
	always @(posedge clk_sys) begin
		if (modeState == ST_STOP) begin
			mainOscRunning <= 1'b0;
			cnt <= 0;
		end else if (!mainOscRunning) begin
			cnt <= cnt + 1;
			if (cnt == START_DLY) begin
				mainOscRunning <= 1'b1;
			end
		end
	end
endmodule

// ===== testbench/shc_standby_halt_control_tb_top.sv
// self-checking bench for the standby and halt control block
`timescale 1ns/10ps
module shc_standby_halt_control_tb_top;
	import shc_pkg::*;
	localparam int L0 = 3;
	localparam int L1 = 4;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic clkEn = 1'b1;
	shc_bus_req_type busReq = '0;
	logic [7:0] busRdata;
	logic haltExec = 1'b0;
	shc_wake_type wakeReq = '0;
	logic mainOscRunning;
	logic settleStrap = 1'b1;
	shc_clk_ctrl_type clkCtrl;
	logic wakeAck;
	shc_state_type modeState;
	int numErrors = 0;
	int checksDone = 0;
	int cycles = 0;
	int ackCnt = 0;
	int n;
	int a;
	logic [7:0] m;

	always #5 clk_sys = ~clk_sys;

	shc_standby_halt_control #(.SETTLE_LOG_0(L0), .SETTLE_LOG_1(L1)) dut (
		.clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .busReq(busReq),
		.busRdata(busRdata), .haltExec(haltExec), .wakeReq(wakeReq),
		.mainOscRunning(mainOscRunning), .settleStrap(settleStrap),
		.clkCtrl(clkCtrl), .wakeAck(wakeAck), .modeState(modeState));

	shc_osc_model osc (.clk_sys(clk_sys), .modeState(modeState),
		.mainOscRunning(mainOscRunning));

	// ************************
	// helpers
	// ************************
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (wakeAck === 1'b1) ackCnt <= ackCnt + 1;
		if (cycles == 20000) begin
			numErrors = numErrors + 1;
			stopTest();
		end
	end

	task automatic stopTest();
		if (numErrors == 0 && checksDone > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		checksDone++;
		if (got !== exp) begin
			numErrors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic bus(logic [3:0] ad, logic [7:0] d, logic w, logic r);
		@(posedge clk_sys);
		busReq <= '{ad, d, w, r};
		@(posedge clk_sys);
		busReq <= '0;
	endtask

	// software side: unlock key then the store itself
	task automatic pwr(logic [3:0] ad, logic [7:0] d);
		bus(ADDR_PROT, PROT_KEY, 1'b1, 1'b0);
		bus(ad, d, 1'b1, 1'b0);
		#1;
	endtask

	task automatic rdchk(string what, logic [3:0] ad, logic [7:0] exp);
		bus(ad, 8'h00, 1'b0, 1'b1);
		#1;
		chk(what, exp, busRdata);
	endtask

	task automatic waitFor(shc_state_type s, int lim, output int k);
		k = 0;
		while (modeState !== s && k < lim) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		if (modeState !== s) chk("state wait", s, modeState);
	endtask

	// no bus traffic from the cpu side right after halt
	task automatic halt();
		@(posedge clk_sys);
		haltExec <= 1'b1;
		@(posedge clk_sys);
		haltExec <= 1'b0;
		#1;
	endtask

	function automatic int settleLen(int c);
		return (1 << (c == 0 ? L0 : L1 + c - 1)) - 1;
	endfunction

	function automatic shc_wake_type wakeSrc(int i);
		shc_wake_type w;
		w = '0;
		w.watchdog2NmiRequest = (i == 0);
		w.nmiPinReq = (i == 1);
		w.maskIrqReq = (i == 2);
		return w;
	endfunction

	// ************************
	// main sequence
	// ************************
	initial begin
		void'($urandom(32'h6DF2A0A1));
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rdchk("psc", ADDR_PSC, 8'h00);
		rdchk("power_save_mode", ADDR_POWER_SAVE_MODE, 8'h00);
		rdchk("oscillation_settle_select", ADDR_OSCILLATION_SETTLE_SELECT, 8'h01);
		bus(ADDR_PSC, 8'h02, 1'b1, 1'b0);
		rdchk("psc plain", ADDR_PSC, 8'h00);
		chk("plain state", ST_NORMAL, modeState);
		m = 8'($urandom()) & PSC_MASKS;
		pwr(ADDR_PSC, m);
		rdchk("psc masks", ADDR_PSC, m);
		pwr(ADDR_PSC, 8'h00);
		pwr(ADDR_PSC, 8'h72);
		rdchk("psc joint", ADDR_PSC, 8'h02);
		chk("idle", ST_IDLE, modeState);
		wakeReq <= wakeSrc(2);
		clkEn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		chk("frozen", ST_IDLE, modeState);
		clkEn <= 1'b1;
		waitFor(ST_NORMAL, 8, n);
		wakeReq <= '0;
		for (int i = 0; i < 3; i++) begin
			m = 8'h40 >> i;
			pwr(ADDR_PSC, m);
			pwr(ADDR_PSC, m | 8'h02);
			wakeReq <= wakeSrc(i);
			repeat (10) @(posedge clk_sys);
			#1;
			chk("masked", ST_IDLE, modeState);
			wakeReq <= wakeSrc((i + 1) % 3);
			waitFor(ST_NORMAL, 8, n);
			wakeReq <= '0;
			rdchk("stby clear", ADDR_PSC, m);
		end
		pwr(ADDR_PSC, 8'h00);
		bus(ADDR_POWER_SAVE_MODE, 8'h81, 1'b1, 1'b0);
		#1;
		chk("subosc", 1, clkCtrl.subOscStop);
		for (int c = 0; c < 8; c++) begin
			bus(ADDR_OSCILLATION_SETTLE_SELECT, 8'(c), 1'b1, 1'b0);
			pwr(ADDR_PSC, 8'h02);
			chk("stop", ST_STOP, modeState);
			chk("oscstop", 1, clkCtrl.mainOscStop);
			wakeReq <= wakeSrc(0);
			waitFor(ST_SETTLE, 60, n);
			chk("osc up", 1, mainOscRunning);
			wakeReq <= '0;
			waitFor(ST_NORMAL, 1100, n);
			chk("settle", settleLen(c), n);
		end
		bus(ADDR_POWER_SAVE_MODE, 8'h00, 1'b1, 1'b0);
		repeat ($urandom_range(1, 4)) @(posedge clk_sys);
		a = ackCnt;
		halt();
		chk("halt", ST_HALT, modeState);
		chk("halt clk", 4'h8, clkCtrl);
		wakeReq <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
		waitFor(ST_NORMAL, 3, n);
		wakeReq <= '0;
		repeat (2) @(posedge clk_sys);
		chk("nmi ack", a + 1, ackCnt);
		for (int p = 0; p < 2; p++) begin
			a = ackCnt;
			wakeReq <= '{1'b0, 1'b0, 1'b0, 1'b1, p[0]};
			halt();
			chk("pend halt", ST_HALT, modeState);
			waitFor(ST_NORMAL, 2, n);
			wakeReq <= '0;
			repeat (2) @(posedge clk_sys);
			chk("prio ack", a + p, ackCnt);
		end
		stopTest();
	end
endmodule
